/* File: rcto_pkg.sv */
// Purpose: constants for the reset-cause and start-up time-out block
// Assumes: 10 MHz mclk, AXI4-Lite register access
// Notes: delays are counted in mclk cycles; the power-up count is derived from its time, the start-up count is fixed
package rcto_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_PWR_STATUS = 8'h00; // Power reset status, two flags
   localparam logic [7:0] ADDR_CORE_STATUS = 8'h04; // Timeout/powerdown, upper status bits
   localparam logic [7:0] ADDR_CONFIG = 8'h08; // Oscillator mode, timer off, brown-out enable
   localparam logic [7:0] ADDR_PC = 8'h0c; // Program counter restart value
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10; // Sticky event bits, write one clears
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14; // Interrupt mask
   localparam logic [7:0] ADDR_STATE = 8'h18; // Sequencer state, in-reset flag
   // Field positions
   localparam int BROWNOUT_BIT = 0; // Brown-out flag in power status
   localparam int POWERON_BIT = 1; // Power-on flag in power status
   localparam int TIMEOUT_BIT = 4; // Timeout flag in core status
   localparam int POWERDOWN_BIT = 3; // Power-down flag in core status
   localparam int CFG_TIMER_OFF_BIT = 2; // Power-up timer off bit in config
   localparam int CFG_BOD_EN_BIT = 3; // Brown-out detect enable in config
   // Reset values
   localparam logic [1:0] PWR_STATUS_RST = 2'h0; // Power-on clears power-on flag
   localparam logic [7:0] CORE_STATUS_POR = 8'h18; // Pattern 0001 1xxx, x taken as 0
   localparam logic [3:0] CONFIG_RST = 4'h0; // Low-power crystal, timer on, no brown-out
   localparam logic [12:0] PC_RESET = 13'h000; // Reset vector
   localparam logic [12:0] PC_IRQ_VECTOR = 13'h004; // Interrupt vector
   // Oscillator modes
   localparam logic [1:0] OSC_LOW_POWER = 2'h0;
   localparam logic [1:0] OSC_STANDARD = 2'h1;
   localparam logic [1:0] OSC_HIGH_SPEED = 2'h2;
   localparam logic [1:0] OSC_RES_CAP = 2'h3;
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int POWERUP_DELAY_MS = 72;
   localparam int POWERUP_CYCLES = POWERUP_DELAY_MS * (CLK_HZ / 1000);
   localparam int OSC_STARTUP_CYCLES = 1024;
   // Event bits for the interrupt status
   localparam int EV_POR = 0;
   localparam int EV_BROWNOUT = 1;
   localparam int EV_WATCHDOG = 2;
   localparam int EV_MASTERCLR = 3;
   localparam int EV_WAKE = 4;
   localparam int EV_RELEASE = 5;
   localparam int EV_WIDTH = 6;
   // Sequencer states
   typedef enum logic [2:0] {
      SEQ_RUN = 3'b001,
      SEQ_PWRUP = 3'b010,
      SEQ_OSC = 3'b100
   } rcto_seq_t;
endpackage

/* File: rcto_delay_counter.sv */
// Purpose: loadable down-counter for the time-out delays
// Assumes: load has priority over counting
// Notes: done pulses one cycle when the count reaches zero
module rcto_delay_counter (
   input wire logic mclk,
   input wire logic rst,
   input wire logic load,
   input wire logic [19:0] loadValue,
   output logic done
);
   logic [19:0] count_ff; // Remaining cycles
   logic running_ff; // Counting in progress

   // Count down from the loaded value; a fresh load restarts at once
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count_ff <= 20'h00000;
         running_ff <= 1'b0;
      end else if (load) begin
         count_ff <= loadValue;
         running_ff <= 1'b1;
      end else if (running_ff && count_ff != 20'h00000) begin
         count_ff <= count_ff - 20'h00001;
      end else begin
         running_ff <= 1'b0;
      end
   end

   // Done as the count runs out; a load in the same cycle overrides it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         done <= 1'b0;
      end else begin
         done <= running_ff && !load && count_ff == 20'h00001;
      end
   end
endmodule

/* File: reset_cause_and_timeout_logic.sv */
// Purpose: records reset causes and holds the core in reset through start-up delays
// Assumes: reset events are one-cycle pulses synchronous to mclk
// Notes: core flags and restart address are readable over AXI4-Lite
//
// Notes on behaviour
// - Brown-out flag bit 0, cleared by brown-out
// - Brown-out flag meaningless while brown-out disabled
// - Power-on flag bit 1, cleared by power-on
// - Crystal: 72 ms plus 1024 or 1024 only
// - RC mode: 72 ms or none, no start-up wait
// - Power-on sets timeout, powerdown, loads zero PC
// - Brown-out, watchdog reset, watchdog wake flag codes
// - Master clear keeps flags, clears upper status
// - Sleep master clear or interrupt wake: timeout1 powerdown0
// - Resets load 000h; wake-ups continue PC+1
// - Interrupt wake with global enable: vector
// - Oscillator count starts after power-up delay
// - Brown-out enable forces power-up delay
module reset_cause_and_timeout_logic (
   input wire logic mclk,
   input wire logic rst,
   input wire logic porEvent,
   input wire logic brownoutEvent,
   input wire logic watchdogEvent,
   input wire logic masterClearEvent,
   input wire logic irqWakeEvent,
   input wire logic sleeping,
   input wire logic globalIrqEnable,
   input wire logic [12:0] currentPc,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic coreReset,
   output logic [12:0] restartPc,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [1:0] pwrStatus_ff; // Power reset status flags
   logic [7:0] coreStatus_ff; // Upper status byte incl. timeout/powerdown
   logic [3:0] config_ff; // Oscillator mode and timer options
   logic [rcto_pkg::EV_WIDTH-1:0] evStat_ff; // Sticky events
   logic [rcto_pkg::EV_WIDTH-1:0] evMask_ff; // Interrupt mask
   rcto_pkg::rcto_seq_t seq_ff; // Delay sequencer state
   logic awHeld_ff, wHeld_ff; // Captured write halves
   logic [7:0] awAddr_ff; // Captured write address
   logic [31:0] wData_ff; // Captured write data
   logic [3:0] wStrb_ff; // Captured strobes
   logic pwrLoad, oscLoad, pwrDone, oscDone; // Counter controls
   logic [rcto_pkg::EV_WIDTH-1:0] events; // Raw event vector
   logic anyReset; // Event that restarts the time-out sequence
   logic needPwrup, needOsc, isCrystal; // Delay selection
   logic doWrite; // Both write halves present
   logic [rcto_pkg::EV_WIDTH-1:0] clrBits; // Write-one-to-clear bits
   logic [31:0] rdValue; // Read mux

   ////////////////////////////////////////////////////////////////////////////
   // Event decode and delay selection
   assign events = {pwrDone | oscDone, irqWakeEvent, masterClearEvent,
                    watchdogEvent, brownoutEvent, porEvent};
   assign isCrystal = config_ff[1:0] != rcto_pkg::OSC_RES_CAP;
   // Power-up delay on power-on with timer on or brown-out detect enabled, always on brown-out
   assign needPwrup = brownoutEvent ||
      (porEvent && (!config_ff[rcto_pkg::CFG_TIMER_OFF_BIT]
                    || config_ff[rcto_pkg::CFG_BOD_EN_BIT]));
   // Start-up wait only in crystal modes; sleep wake-ups count too
   assign needOsc = isCrystal &&
      (porEvent || brownoutEvent || (sleeping && (watchdogEvent || irqWakeEvent)));
   assign anyReset = porEvent | brownoutEvent | watchdogEvent | masterClearEvent |
                     (sleeping & irqWakeEvent);
   // A new event reloads only the counter it needs; a counter it does not load keeps counting its old run
   assign pwrLoad = anyReset && needPwrup;
   assign oscLoad = (anyReset && !needPwrup && needOsc) ||
                    (seq_ff == rcto_pkg::SEQ_PWRUP && pwrDone && isCrystal);

   rcto_delay_counter u_pwrup (
      .mclk(mclk),
      .rst(rst),
      .load(pwrLoad),
      .loadValue(20'(rcto_pkg::POWERUP_CYCLES)),
      .done(pwrDone)
   );

   rcto_delay_counter u_osc (
      .mclk(mclk),
      .rst(rst),
      .load(oscLoad),
      .loadValue(20'(rcto_pkg::OSC_STARTUP_CYCLES)),
      .done(oscDone)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: power-up delay, then oscillator count, then run
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         seq_ff <= rcto_pkg::SEQ_RUN;
      end else if (pwrLoad) begin
         seq_ff <= rcto_pkg::SEQ_PWRUP;
      end else if (oscLoad) begin
         seq_ff <= rcto_pkg::SEQ_OSC;
      end else begin
         case (seq_ff)
            rcto_pkg::SEQ_PWRUP: begin
               if (pwrDone) begin
                  seq_ff <= rcto_pkg::SEQ_RUN; // RC mode ends here
               end
            end
            rcto_pkg::SEQ_OSC: begin
               if (oscDone) begin
                  seq_ff <= rcto_pkg::SEQ_RUN;
               end
            end
            default: begin
               seq_ff <= rcto_pkg::SEQ_RUN;
            end
         endcase
      end
   end

   // Core reset held while a delay runs or a master clear is asserted
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         coreReset <= 1'b1;
      end else begin
         coreReset <= pwrLoad || oscLoad || anyReset ||
                      (seq_ff != rcto_pkg::SEQ_RUN && !(pwrDone && !isCrystal) && !oscDone);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter restart value
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         restartPc <= rcto_pkg::PC_RESET;
      end else if (porEvent || brownoutEvent || masterClearEvent ||
                   (watchdogEvent && !sleeping)) begin
         restartPc <= rcto_pkg::PC_RESET;
      end else if (sleeping && irqWakeEvent && globalIrqEnable) begin
         restartPc <= rcto_pkg::PC_IRQ_VECTOR;
      end else if (sleeping && (watchdogEvent || irqWakeEvent)) begin
         restartPc <= currentPc + 13'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power reset status: hardware clears win over software writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pwrStatus_ff <= rcto_pkg::PWR_STATUS_RST;
      end else begin
         if (doWrite && awAddr_ff == rcto_pkg::ADDR_PWR_STATUS && wStrb_ff[0]) begin
            pwrStatus_ff <= wData_ff[1:0]; // Software sets flags
         end
         if (porEvent) begin
            pwrStatus_ff[rcto_pkg::POWERON_BIT] <= 1'b0;
         end
         // Brown-out flag just follows events; unreliable if detect is off
         if (brownoutEvent) begin
            pwrStatus_ff[rcto_pkg::BROWNOUT_BIT] <= 1'b0;
         end
      end
   end

   // Core status: timeout and power-down encodings per cause
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         coreStatus_ff <= rcto_pkg::CORE_STATUS_POR;
      end else if (porEvent || brownoutEvent) begin
         coreStatus_ff <= rcto_pkg::CORE_STATUS_POR;
      end else if (watchdogEvent && sleeping) begin
         coreStatus_ff[rcto_pkg::TIMEOUT_BIT] <= 1'b0; // Watchdog wake
         coreStatus_ff[rcto_pkg::POWERDOWN_BIT] <= 1'b0;
      end else if (watchdogEvent) begin
         coreStatus_ff[7:5] <= 3'h0;
         coreStatus_ff[rcto_pkg::TIMEOUT_BIT] <= 1'b0;
         coreStatus_ff[rcto_pkg::POWERDOWN_BIT] <= 1'b1;
      end else if (masterClearEvent) begin
         coreStatus_ff[7:5] <= 3'h0;
         if (sleeping) begin
            coreStatus_ff[rcto_pkg::TIMEOUT_BIT] <= 1'b1;
            coreStatus_ff[rcto_pkg::POWERDOWN_BIT] <= 1'b0;
         end
      end else if (irqWakeEvent && sleeping) begin
         coreStatus_ff[rcto_pkg::TIMEOUT_BIT] <= 1'b1;
         coreStatus_ff[rcto_pkg::POWERDOWN_BIT] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration, mask and sticky events
   assign clrBits = (doWrite && awAddr_ff == rcto_pkg::ADDR_IRQ_STAT && wStrb_ff[0]) ?
                    wData_ff[rcto_pkg::EV_WIDTH-1:0] : '0;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         config_ff <= rcto_pkg::CONFIG_RST;
         evMask_ff <= '0;
      end else if (doWrite && wStrb_ff[0]) begin
         if (awAddr_ff == rcto_pkg::ADDR_CONFIG) begin
            config_ff <= wData_ff[3:0];
         end else if (awAddr_ff == rcto_pkg::ADDR_IRQ_MASK) begin
            evMask_ff <= wData_ff[rcto_pkg::EV_WIDTH-1:0];
         end
      end
   end

   // New events win over a same-cycle clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         evStat_ff <= '0;
         irq <= 1'b0;
      end else begin
         evStat_ff <= (evStat_ff & ~clrBits) | events;
         irq <= |(((evStat_ff & ~clrBits) | events) & evMask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write: take address and data in any order, answer after both
   assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         awAddr_ff <= 8'h00;
         wData_ff <= 32'h00000000;
         wStrb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Ready one cycle at a time; write halves refused while a reply is pending
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !awHeld_ff && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
         s_axi_wready <= !wHeld_ff && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      end
   end

   // Unmapped write addresses get OKAY and are dropped
   assign s_axi_bresp = 2'b00;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read
   always_comb begin
      rdValue = 32'h00000000;
      if (s_axi_araddr[7:0] == rcto_pkg::ADDR_PWR_STATUS) begin
         rdValue[1:0] = pwrStatus_ff;
      end else if (s_axi_araddr[7:0] == rcto_pkg::ADDR_CORE_STATUS) begin
         rdValue[7:0] = coreStatus_ff;
      end else if (s_axi_araddr[7:0] == rcto_pkg::ADDR_CONFIG) begin
         rdValue[3:0] = config_ff;
      end else if (s_axi_araddr[7:0] == rcto_pkg::ADDR_PC) begin
         rdValue[12:0] = restartPc;
      end else if (s_axi_araddr[7:0] == rcto_pkg::ADDR_IRQ_STAT) begin
         rdValue[rcto_pkg::EV_WIDTH-1:0] = evStat_ff;
      end else if (s_axi_araddr[7:0] == rcto_pkg::ADDR_IRQ_MASK) begin
         rdValue[rcto_pkg::EV_WIDTH-1:0] = evMask_ff;
      end else if (s_axi_araddr[7:0] == rcto_pkg::ADDR_STATE) begin
         rdValue[3:0] = {coreReset, seq_ff};
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdValue;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Reads always answer OKAY; unmapped offsets return zero
   assign s_axi_rresp = 2'b00;
endmodule

/* File: reset_cause_and_timeout_logic_chk.sv */
// Purpose: port-level checks of the reset-cause and time-out block
// Assumes: the bench holds currentPc steady around wake events
// Notes: attached by bind to every instance of the block
module rcto_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic porEvent,
   input wire logic brownoutEvent,
   input wire logic watchdogEvent,
   input wire logic masterClearEvent,
   input wire logic irqWakeEvent,
   input wire logic sleeping,
   input wire logic globalIrqEnable,
   input wire logic [12:0] currentPc,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic coreReset,
   input wire logic [12:0] restartPc
);
   // One clock domain, so one default clocking and disable
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Resets restart at the vector, wakes continue, enabled wakes vector
   chk_reset_pc_zero:
   assert property ((porEvent || brownoutEvent || masterClearEvent || (watchdogEvent && !sleeping))
      |-> ##[1:2] restartPc == 13'h000) else $error("restart address not the reset vector");
   chk_wake_pc_next:
   assert property (sleeping && (watchdogEvent || (irqWakeEvent && !globalIrqEnable))
      |-> ##[1:2] restartPc == currentPc + 13'h001) else $error("wake address not next address");
   chk_irq_vector:
   assert property (sleeping && irqWakeEvent && globalIrqEnable
      |-> ##[1:2] restartPc == 13'h004) else $error("enabled wake did not vector");
   // Brown-out always holds the core for the long delay, so at least eight cycles
   chk_brownout_hold:
   assert property (brownoutEvent |-> ##[1:2] coreReset [*8]) else $error("brown-out not held");
   ////////////////////////////////////////////////////////////////////////////////
   // Register bus handshakes
   chk_arready_pulse:
   assert property (s_axi_arready |=> !s_axi_arready) else $error("arready longer than a cycle");
   chk_read_answer:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
   chk_rdata_hold:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed");
   chk_bvalid_hold:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   chk_resp_okay:
   assert property (s_axi_bvalid || s_axi_rvalid |-> (s_axi_bresp | s_axi_rresp) == 2'h0)
      else $error("response not okay");
endmodule
bind reset_cause_and_timeout_logic rcto_chk rcto_chk_i (.*);

/* File: testbench.sv */
// Purpose: register-level bench of the reset-cause and time-out block
// Assumes: events are one-cycle pulses; the long power-up delay is never run out
// Notes: long delays are only shown to outlast the start-up count
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] ev = 5'h00; // Pulses: por, brown-out, watchdog, master clear, irq wake
   wire porEvent = ev[0];
   wire brownoutEvent = ev[1];
   wire watchdogEvent = ev[2];
   wire masterClearEvent = ev[3];
   wire irqWakeEvent = ev[4];
   logic sleeping = 1'b0;
   logic globalIrqEnable = 1'b0;
   logic [12:0] currentPc = 13'h0abc; // Held steady so wake addresses are predictable
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic coreReset, irq;
   logic [12:0] restartPc;
   int n_errors = 0;
   int comparisons = 0;
   reset_cause_and_timeout_logic reset_cause_and_timeout_logic_i (.*);
   // 10 MHz clock
   always #50 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // A wait that ran out counts as a mismatch
   task automatic timed_out;
      n_errors++;
      tally_and_finish();
   endtask
   // Write: address and data offered together, response waited for with bready late
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (i = 0; i < 20 && !(aw && w); i++) begin
         @(posedge mclk);
         if (s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            aw = 1'b1;
         end
         if (s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            w = 1'b1;
         end
      end
      if (!(aw && w)) timed_out();
      @(posedge mclk);
      s_axi_bready <= 1'b1;
      // Look only at edges where bready already stands, so the answer is taken there
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (s_axi_bvalid) break;
      end
      if (i >= 20) timed_out();
      s_axi_bready <= 1'b0;
   endtask
   // Read: rready raised a cycle late so the answer must stand
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int i;
      @(posedge mclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      for (i = 0; i < 20 && !s_axi_arready; i++) @(posedge mclk);
      if (i >= 20) timed_out();
      s_axi_arvalid <= 1'b0;
      @(posedge mclk);
      s_axi_rready <= 1'b1;
      // rready must be seen high with rvalid, else the answer never retires
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (s_axi_rvalid) break;
      end
      if (i >= 20) timed_out();
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      `CHECK(d & m, e)
   endtask
   // One-cycle event pulse, k picks the cause
   task automatic fire(input int k);
      @(posedge mclk);
      ev <= 5'h01 << k;
      @(posedge mclk);
      ev <= 5'h00;
   endtask
   // Counts how long the core stays held after an event
   task automatic hold_range(input int lo, input int hi);
      int n;
      n = 0;
      repeat (2) @(posedge mclk);
      while (coreReset && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 3000) timed_out();
      `CHECK(n >= lo && n <= hi, 1'b1)
   endtask
   task automatic osc_hold;
      hold_range(rcto_pkg::OSC_STARTUP_CYCLES - 6, rcto_pkg::OSC_STARTUP_CYCLES + 6);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      expect_reg(rcto_pkg::ADDR_PWR_STATUS, 32'h3, 32'h0);
      expect_reg(rcto_pkg::ADDR_CORE_STATUS, 32'hff, 32'h18);
      `CHECK(restartPc, rcto_pkg::PC_RESET)
      expect_reg(8'h20, 32'hffffffff, 32'h0);
      wr(rcto_pkg::ADDR_PWR_STATUS, 32'h3);
      expect_reg(rcto_pkg::ADDR_PWR_STATUS, 32'h3, 32'h3);
      // Low-power crystal, timer off: power-up waits only for the start-up count
      wr(rcto_pkg::ADDR_CONFIG, 32'h4);
      expect_reg(rcto_pkg::ADDR_CONFIG, 32'hf, 32'h4);
      fire(0);
      osc_hold();
      expect_reg(rcto_pkg::ADDR_PWR_STATUS, 32'h2, 32'h0);
      expect_reg(rcto_pkg::ADDR_CORE_STATUS, 32'h18, 32'h18);
      wr(rcto_pkg::ADDR_PWR_STATUS, 32'h3);
      // Watchdog reset, with its event bit masked then unmasked
      wr(rcto_pkg::ADDR_IRQ_STAT, 32'h3f);
      wr(rcto_pkg::ADDR_IRQ_MASK, 32'h0);
      fire(2);
      hold_range(0, 3000);
      expect_reg(rcto_pkg::ADDR_CORE_STATUS, 32'hf8, 32'h08);
      expect_reg(rcto_pkg::ADDR_PWR_STATUS, 32'h3, 32'h3);
      expect_reg(rcto_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
      `CHECK(irq, 1'b0)
      wr(rcto_pkg::ADDR_IRQ_MASK, 32'h4);
      // The registered interrupt follows the new mask one edge later
      @(posedge mclk);
      `CHECK(irq, 1'b1)
      wr(rcto_pkg::ADDR_IRQ_STAT, 32'h4);
      `CHECK(irq, 1'b0)
      // Watchdog wake in crystal mode
      sleeping <= 1'b1;
      fire(2);
      osc_hold();
      `CHECK(restartPc, currentPc + 13'h001)
      expect_reg(rcto_pkg::ADDR_CORE_STATUS, 32'h18, 32'h00);
      // Master clear awake keeps flags; asleep gives timeout set, power-down clear
      sleeping <= 1'b0;
      fire(3);
      hold_range(0, 3000);
      expect_reg(rcto_pkg::ADDR_CORE_STATUS, 32'hf8, 32'h00);
      `CHECK(restartPc, rcto_pkg::PC_RESET)
      sleeping <= 1'b1;
      fire(3);
      hold_range(0, 3000);
      expect_reg(rcto_pkg::ADDR_CORE_STATUS, 32'h18, 32'h10);
      // Resistor-capacitor mode: interrupt wakes have no start-up wait
      sleeping <= 1'b0;
      wr(rcto_pkg::ADDR_CONFIG, 32'h7);
      fire(2);
      hold_range(0, 3000);
      sleeping <= 1'b1;
      fire(4);
      hold_range(0, 2);
      `CHECK(restartPc, currentPc + 13'h001)
      expect_reg(rcto_pkg::ADDR_CORE_STATUS, 32'h18, 32'h10);
      globalIrqEnable <= 1'b1;
      fire(4);
      hold_range(0, 2);
      `CHECK(restartPc, rcto_pkg::PC_IRQ_VECTOR)
      sleeping <= 1'b0;
      globalIrqEnable <= 1'b0;
      // Brown-out forces the long delay although the timer is off
      wr(rcto_pkg::ADDR_CONFIG, 32'hd);
      fire(1);
      repeat (1100) @(posedge mclk);
      `CHECK(coreReset, 1'b1)
      expect_reg(rcto_pkg::ADDR_PWR_STATUS, 32'h3, 32'h2);
      expect_reg(rcto_pkg::ADDR_CORE_STATUS, 32'h18, 32'h18);
      // Power-on with brown-out detect enabled also takes the long delay
      fire(0);
      repeat (1100) @(posedge mclk);
      `CHECK(coreReset, 1'b1)
      // A power-on in mid-delay, high-speed crystal, restarts with only the start-up count
      wr(rcto_pkg::ADDR_CONFIG, 32'h6);
      fire(0);
      osc_hold();
      tally_and_finish();
   end
endmodule
